// *** hbp_consts.svh ***
// Purpose: shared constants of the host bus port (offsets, lanes, reset values)
// Assumes: included by bare name from every design file that needs it
// Notes: definitions only, no logic
`ifndef HBP_CONSTS_SVH
`define HBP_CONSTS_SVH

// ----------------------------------------------------------------------------
// register map (word index taken from register_select[2:1])
// ----------------------------------------------------------------------------
`define HBP_NUM_REGS 4
`define HBP_REG_W 16
`define HBP_IDX_W 2
`define HBP_TX_DATA_STATUS_IDX 2'h3

// ----------------------------------------------------------------------------
// byte lanes and byte enables
// ----------------------------------------------------------------------------
`define HBP_LANE_W 8
`define HBP_LO_LANE_LSB 0
`define HBP_HI_LANE_LSB 8
`define HBP_BE_LO 2'h1
`define HBP_BE_HI 2'h2
`define HBP_BE_WORD 2'h3
`define HBP_BE_NONE 2'h0

// ----------------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------------
`define HBP_REG_RESET 16'h0000
`define HBP_BUS_RESET 16'h0000
`define HBP_TBE_RESET 1'h0

`endif

// *** hbp_pkg.sv ***
// Purpose: types shared by the host bus port modules
// Assumes: nothing beyond a SystemVerilog compiler
// Notes: used only through hbp_pkg::name
package hbp_pkg;

	// ------------------------------------------------------------------------
	// host control pins, carried together through the synchroniser
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [2:0] register_select;
		logic byte_sel;
		logic chip_enable;
		logic dir_write;
		logic bus_strobe;
		logic reset_req;
	} hbp_ctl_t;

	// ------------------------------------------------------------------------
	// one decoded access: word index and byte enables
	// ------------------------------------------------------------------------
	typedef struct packed {
		logic [1:0] idx;
		logic [1:0] be;
	} hbp_access_t;

	// ------------------------------------------------------------------------
	// strobe sequencer states
	// ------------------------------------------------------------------------
	typedef enum logic [1:0] {
		HBP_IDLE = 2'b00,
		HBP_READ = 2'b01,
		HBP_WRITE_END = 2'b10,
		HBP_IGNORE = 2'b11
	} hbp_state_t;

endpackage : hbp_pkg

// *** hbp_pin_sync.sv ***
// Purpose: three-stage pin synchroniser with agreement filter
// Assumes: inputs are asynchronous to core_clk
// Notes: output moves only when stages two and three agree
`timescale 1ns/1ps
module hbp_pin_sync #(
	parameter int W = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// pins in, settled levels out
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level_q
);

	logic [W-1:0] s1_q;
	logic [W-1:0] s2_q;
	logic [W-1:0] s3_q;
	logic [W-1:0] agree;

	// a bit counts as changed once the last two stages hold the same value
	assign agree = ~(s2_q ^ s3_q);

	// s1 feeds s2 only, so metastability never reaches the filter
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			s1_q <= '0;
			s2_q <= '0;
			s3_q <= '0;
			level_q <= '0;
		end
		else
		begin
			s1_q <= pin_in;
			s2_q <= s1_q;
			s3_q <= s2_q;
			level_q <= (s2_q & agree) | (level_q & ~agree);
		end
	end

endmodule : hbp_pin_sync

// *** hbp_reg_bank.sv ***
// Purpose: the four 16-bit host registers with byte writes and registered read
// Assumes: one write per cycle at most, byte enables one per lane
// Notes: synchronous clear wipes every word to the reset value
`timescale 1ns/1ps
`include "hbp_consts.svh"
module hbp_reg_bank #(
	parameter int NUM = `HBP_NUM_REGS,
	parameter int DW = `HBP_REG_W,
	parameter int IW = `HBP_IDX_W
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	input wire logic clr,
	// write side
	input wire logic wr_en,
	input wire logic [IW-1:0] wr_idx,
	input wire logic [1:0] wr_be,
	input wire logic [DW-1:0] wr_data,
	// read side
	input wire logic [IW-1:0] rd_idx,
	output logic [DW-1:0] rd_data_q,
	// whole contents for the serial core
	output logic [NUM*DW-1:0] regs_q
);

	localparam int LW = DW / 2;

	logic [DW-1:0] mem_q [NUM];

	// each word keeps its lanes unless addressed with the matching enable
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			for (int i = 0; i < NUM; i++)
				mem_q[i] <= `HBP_REG_RESET;
		end
		else if (clr)
		begin
			for (int i = 0; i < NUM; i++)
				mem_q[i] <= `HBP_REG_RESET;
		end
		else if (wr_en)
		begin
			if (wr_be[0])
				mem_q[wr_idx][LW-1:0] <= wr_data[LW-1:0];
			if (wr_be[1])
				mem_q[wr_idx][DW-1:LW] <= wr_data[DW-1:LW];
		end
	end

	// read data comes from a register, one cycle after the index
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			rd_data_q <= `HBP_REG_RESET;
		else
			rd_data_q <= clr ? `HBP_REG_RESET : mem_q[rd_idx];
	end

	// flatten for the core side
	always_comb
	begin
		for (int i = 0; i < NUM; i++)
			regs_q[i*DW +: DW] = mem_q[i];
	end

endmodule : hbp_reg_bank

// *** hbp_host_port.sv ***
// Purpose: processor-side parallel bus port of the serial controller
// Assumes: host pins are asynchronous; tx_slot_free comes from core_clk logic
// Notes: data pins are split into in, out and enable; the pad ring resolves them
`timescale 1ns/1ps
`include "hbp_consts.svh"
module hbp_host_port #(
	parameter int DW = `HBP_REG_W,
	parameter int NUM = `HBP_NUM_REGS
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// host data pins, split into three signals each
	input wire logic [DW-1:0] host_data_lines_in,
	output logic [DW-1:0] host_data_lines_out,
	output logic [DW-1:0] host_data_lines_oe,
	// host control pins
	input wire logic [2:0] register_select,
	input wire logic byte_sel,
	input wire logic chip_enable,
	input wire logic rw_dir,
	input wire logic bus_strobe,
	input wire logic reset_pin,
	// transmit handshake pin
	output logic tx_buffer_empty,
	// serial core side
	input wire logic tx_slot_free,
	output logic [NUM*DW-1:0] reg_file_q,
	output logic host_wr_pulse_q,
	output logic host_rd_pulse_q,
	output hbp_pkg::hbp_access_t host_acc_q
);

	localparam int CW = $bits(hbp_pkg::hbp_ctl_t);

	// ------------------------------------------------------------------------
	// pin synchronisation
	// ------------------------------------------------------------------------

	hbp_pkg::hbp_ctl_t ctl_pins;
	hbp_pkg::hbp_ctl_t ctl;
	logic [DW-1:0] din;

	// control pins travel as one group so they settle together
	assign ctl_pins.register_select = register_select;
	assign ctl_pins.byte_sel = byte_sel;
	assign ctl_pins.chip_enable = chip_enable;
	assign ctl_pins.dir_write = rw_dir;
	assign ctl_pins.bus_strobe = bus_strobe;
	assign ctl_pins.reset_req = reset_pin;

	hbp_pin_sync #(
		.W(CW)
	) u_ctl_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin_in(ctl_pins),
		.level_q(ctl)
	);

	// data pins pass the same three stages, so they line up with the strobe
	hbp_pin_sync #(
		.W(DW)
	) u_data_sync (
		.core_clk(core_clk),
		.rstn(rstn),
		.pin_in(host_data_lines_in),
		.level_q(din)
	);

	// ------------------------------------------------------------------------
	// address and lane decode
	// ------------------------------------------------------------------------

	logic [1:0] word_idx;
	logic hi_byte;
	logic [1:0] acc_be;
	logic soft_reset;
	logic strobe_on;
	logic sel_on;
	logic wr_tx_reg;

	// word from the upper two select lines, byte from the lowest one
	assign word_idx = ctl.register_select[2:1];
	assign hi_byte = ctl.register_select[0];
	// byte mode enables one lane, word mode both
	assign acc_be = ctl.byte_sel ? (hi_byte ? `HBP_BE_HI : `HBP_BE_LO) : `HBP_BE_WORD;
	assign soft_reset = ctl.reset_req;
	assign strobe_on = ctl.bus_strobe;
	// enable must be high together with the strobe for any transfer
	assign sel_on = ctl.bus_strobe & ctl.chip_enable;

	// ------------------------------------------------------------------------
	// strobe sequencer
	// ------------------------------------------------------------------------

	hbp_pkg::hbp_state_t state_q;
	hbp_pkg::hbp_state_t state_d;
	logic wr_go;
	logic rd_go;

	// the strobe's leading edge is seen in idle; enable then decides its fate
	always_comb
	begin
		state_d = state_q;
		wr_go = 1'b0;
		rd_go = 1'b0;
		case (state_q)
			hbp_pkg::HBP_IDLE:
			begin
				if (strobe_on)
				begin
					if (!ctl.chip_enable)
						state_d = hbp_pkg::HBP_IGNORE;
					else if (ctl.dir_write)
					begin
						wr_go = 1'b1;
						state_d = hbp_pkg::HBP_WRITE_END;
					end
					else
					begin
						rd_go = 1'b1;
						state_d = hbp_pkg::HBP_READ;
					end
				end
			end
			hbp_pkg::HBP_READ:
			begin
				if (!sel_on)
					state_d = hbp_pkg::HBP_IDLE;
			end
			hbp_pkg::HBP_WRITE_END:
			begin
				// one write per strobe, however long it is held
				if (!strobe_on)
					state_d = hbp_pkg::HBP_IDLE;
			end
			hbp_pkg::HBP_IGNORE:
			begin
				// a late rise of enable must not turn this strobe into a transfer
				if (!strobe_on)
					state_d = hbp_pkg::HBP_IDLE;
			end
			default:
			begin
				state_d = hbp_pkg::HBP_IDLE;
			end
		endcase
	end

	// reset pin restarts the sequencer from idle
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			state_q <= hbp_pkg::HBP_IDLE;
		else if (soft_reset)
			state_q <= hbp_pkg::HBP_IDLE;
		else
			state_q <= state_d;
	end

	// ------------------------------------------------------------------------
	// register bank
	// ------------------------------------------------------------------------

	logic [DW-1:0] rd_word;
	logic bank_wr;

	// the host's data, already settled, is taken at the strobe's start
	assign bank_wr = wr_go & ~soft_reset;
	assign wr_tx_reg = bank_wr & (word_idx == `HBP_TX_DATA_STATUS_IDX);

	hbp_reg_bank #(
		.NUM(NUM),
		.DW(DW),
		.IW(`HBP_IDX_W)
	) u_bank (
		.core_clk(core_clk),
		.rstn(rstn),
		.clr(soft_reset),
		.wr_en(bank_wr),
		.wr_idx(word_idx),
		.wr_be(acc_be),
		.wr_data(din),
		.rd_idx(word_idx),
		.rd_data_q(rd_word),
		.regs_q(reg_file_q)
	);

	// ------------------------------------------------------------------------
	// read drivers
	// ------------------------------------------------------------------------

	logic rd_active;
	logic rd_active_q;
	logic [1:0] rd_be_q;
	logic [DW-1:0] lane_oe;

	// drivers only in a read that began with enable high
	assign rd_active = (state_q == hbp_pkg::HBP_READ) & sel_on & ~soft_reset;
	// a byte read drives its own lane only, keeping the other free for wire-OR
	assign lane_oe = {{(DW/2){rd_be_q[1]}}, {(DW/2){rd_be_q[0]}}};

	// one stage of delay so the enable meets the registered read data
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			rd_active_q <= 1'b0;
			rd_be_q <= `HBP_BE_NONE;
		end
		else
		begin
			rd_active_q <= rd_active;
			rd_be_q <= rd_active ? acc_be : `HBP_BE_NONE;
		end
	end

	// data on bits 7..0, control and status on 15..8, each at its own lane
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			host_data_lines_out <= `HBP_BUS_RESET;
			host_data_lines_oe <= '0;
		end
		else if (rd_active_q & rd_active)
		begin
			host_data_lines_out <= rd_word & lane_oe;
			host_data_lines_oe <= lane_oe;
		end
		else
		begin
			host_data_lines_out <= `HBP_BUS_RESET;
			host_data_lines_oe <= '0;
		end
	end

	// ------------------------------------------------------------------------
	// transmit buffer empty
	// ------------------------------------------------------------------------

	logic tbe_d;

	// the core's free-slot pulse wins over a host write in the same cycle
	assign tbe_d = tx_slot_free ? 1'b1 : (wr_tx_reg ? 1'b0 : tx_buffer_empty);

	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
			tx_buffer_empty <= `HBP_TBE_RESET;
		else if (soft_reset)
			tx_buffer_empty <= `HBP_TBE_RESET;
		else
			tx_buffer_empty <= tbe_d;
	end

	// ------------------------------------------------------------------------
	// access report to the serial core
	// ------------------------------------------------------------------------

	// one pulse per accepted strobe; the core uses reads to clear its own flags
	always_ff @(posedge core_clk or negedge rstn)
	begin
		if (!rstn)
		begin
			host_wr_pulse_q <= 1'b0;
			host_rd_pulse_q <= 1'b0;
			host_acc_q <= '0;
		end
		else
		begin
			host_wr_pulse_q <= bank_wr;
			host_rd_pulse_q <= rd_go & ~soft_reset;
			if ((wr_go | rd_go) & ~soft_reset)
			begin
				host_acc_q.idx <= word_idx;
				host_acc_q.be <= acc_be;
			end
			else if (soft_reset)
				host_acc_q <= '0;
		end
	end

endmodule : hbp_host_port

// *** hbp_host_port_sva.sv ***
// Purpose: concurrent checks on the host bus port pins
// Assumes: the host keeps setup and spacing; pins pass a 3-4 edge synchroniser
// Notes: windows are sized for the worst synchroniser delay
`timescale 1ns/1ps
module hbp_host_port_sva #(
	parameter int DW = 16,
	parameter int NUM = 4
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic rstn,
	// host pins
	input wire logic [DW-1:0] host_data_lines_out,
	input wire logic [DW-1:0] host_data_lines_oe,
	input wire logic chip_enable,
	input wire logic rw_dir,
	input wire logic bus_strobe,
	input wire logic reset_pin,
	input wire logic tx_buffer_empty,
	// core side
	input wire logic tx_slot_free,
	input wire logic [NUM*DW-1:0] reg_file_q,
	input wire logic host_wr_pulse_q,
	input wire logic host_rd_pulse_q,
	input wire hbp_pkg::hbp_access_t host_acc_q
);
	// --------
	// checks
	// --------
	default clocking @(posedge core_clk); endclocking
	default disable iff (!rstn);

	AST_FLOAT_CE: assert property ((!chip_enable) [*8] |-> host_data_lines_oe == '0)
		else $error("data lines driven with chip enable low");
	AST_FLOAT_STB: assert property ((!bus_strobe) [*8] |-> host_data_lines_oe == '0)
		else $error("data lines driven with strobe low");
	AST_OUT_ZERO: assert property ((host_data_lines_out & ~host_data_lines_oe) == '0)
		else $error("value on an undriven line");
	// the drivers come on two edges after the read pulse, once the delayed enable meets the data
	AST_RD_LANE: assert property (host_rd_pulse_q |-> ##2 host_data_lines_oe ==
		{{8{$past(host_acc_q.be[1], 2)}}, {8{$past(host_acc_q.be[0], 2)}}})
		else $error("read lanes do not match access");
	AST_WR_ONCE: assert property (host_wr_pulse_q |=> (!host_wr_pulse_q) [*4])
		else $error("second write from one strobe");
	AST_DIR: assert property (host_wr_pulse_q || host_rd_pulse_q |->
		host_wr_pulse_q == $past(rw_dir, 2))
		else $error("transfer direction wrong");
	AST_NO_CE: assert property ((!chip_enable) [*6] |-> !host_wr_pulse_q && !host_rd_pulse_q)
		else $error("transfer with chip enable low");
	AST_TBE_FALL: assert property (host_wr_pulse_q && host_acc_q.idx == 2'h3 &&
		!$past(tx_slot_free) |-> !tx_buffer_empty)
		else $error("tx buffer empty kept after word 3 write");
	AST_TBE_RISE: assert property (tx_slot_free |=> tx_buffer_empty)
		else $error("tx buffer empty not raised");
	AST_RESET_CLR: assert property (reset_pin [*8] |-> reg_file_q == '0 &&
		!tx_buffer_empty && host_data_lines_oe == '0)
		else $error("state not cleared by reset pin");
endmodule : hbp_host_port_sva

bind hbp_host_port hbp_host_port_sva #(.DW(DW), .NUM(NUM)) u_sva (.core_clk(core_clk),
	.rstn(rstn), .host_data_lines_out(host_data_lines_out),
	.host_data_lines_oe(host_data_lines_oe), .chip_enable(chip_enable), .rw_dir(rw_dir),
	.bus_strobe(bus_strobe), .reset_pin(reset_pin), .tx_buffer_empty(tx_buffer_empty),
	.tx_slot_free(tx_slot_free), .reg_file_q(reg_file_q), .host_wr_pulse_q(host_wr_pulse_q),
	.host_rd_pulse_q(host_rd_pulse_q), .host_acc_q(host_acc_q));

// *** hbp_host_model.sv ***
// Purpose: behavioural host processor on the parallel bus
// Assumes: one transfer at a time, called from the testbench
// Notes: released lines show the inverse of their last level, so stale data never matches
`timescale 1ns/1ps
module hbp_host_model (
	// clock
	input wire logic core_clk,
	// resolved data bus
	input wire logic [15:0] dev_out,
	input wire logic [15:0] dev_oe,
	output logic [15:0] bus_in,
	// control pins
	output logic [2:0] register_select,
	output logic byte_sel,
	output logic chip_enable,
	output logic rw_dir,
	output logic bus_strobe
);
	logic [15:0] host_drv;
	logic host_oe;
	logic [15:0] last_q;

	// wire level from both parties' enables
	assign bus_in = host_oe ? host_drv : ((dev_out & dev_oe) | (~last_q & ~dev_oe));

	// plain always, since the initial block also gives last_q its start value
	always @(posedge core_clk)
		last_q <= bus_in;

	initial
	begin
		{register_select, byte_sel, chip_enable, rw_dir, bus_strobe} = '0;
		host_drv = 16'h0000;
		host_oe = 1'b0;
		last_q = 16'h0000;
	end

	// --------
	// one strobed transfer
	// --------
	task automatic xfer(input logic wr, input logic [2:0] sel, input logic bsel,
		input logic ce, input logic [15:0] wdata, output logic [15:0] rdata);
		@(posedge core_clk);
		#1;
		register_select = sel;
		byte_sel = bsel; // matches the bus width used
		chip_enable = ce;
		rw_dir = wr;
		host_drv = wdata;
		host_oe = wr;
		repeat (4) @(posedge core_clk); // settle before strobing
		#1;
		bus_strobe = 1'b1;
		// drive starts 7 edges after the strobe rises; sample a full edge later, off the edge
		repeat (8) @(posedge core_clk);
		#1;
		rdata = bus_in;
		bus_strobe = 1'b0;
		repeat (5) @(posedge core_clk); // data held until strobe seen low
		#1;
		host_oe = 1'b0;
		chip_enable = 1'b0;
	endtask : xfer
endmodule : hbp_host_model

// *** tb_top.sv ***
// Purpose: self-checking bench for the host bus port
// Assumes: host model keeps setup and spacing
// Notes: expectations come from a local register image
`timescale 1ns/1ps
module tb_top;
	logic core_clk;
	logic rstn;
	logic reset_pin;
	logic tx_slot_free;
	logic [15:0] bus_in;
	logic [15:0] dev_out;
	logic [15:0] dev_oe;
	logic [2:0] register_select;
	logic byte_sel;
	logic chip_enable;
	logic rw_dir;
	logic bus_strobe;
	logic tx_buffer_empty;
	logic [63:0] reg_file_q;
	logic [15:0] exp_q [4];
	logic [15:0] rd;
	int miscompares = 0;
	int total_checks = 0;

	hbp_host_port DUT (.core_clk(core_clk), .rstn(rstn), .host_data_lines_in(bus_in),
		.host_data_lines_out(dev_out), .host_data_lines_oe(dev_oe),
		.register_select(register_select), .byte_sel(byte_sel), .chip_enable(chip_enable),
		.rw_dir(rw_dir), .bus_strobe(bus_strobe), .reset_pin(reset_pin),
		.tx_buffer_empty(tx_buffer_empty), .tx_slot_free(tx_slot_free),
		.reg_file_q(reg_file_q), .host_wr_pulse_q(), .host_rd_pulse_q(), .host_acc_q());

	hbp_host_model HOST (.core_clk(core_clk), .dev_out(dev_out), .dev_oe(dev_oe),
		.bus_in(bus_in), .register_select(register_select), .byte_sel(byte_sel),
		.chip_enable(chip_enable), .rw_dir(rw_dir), .bus_strobe(bus_strobe));

	initial
	begin
		core_clk = 1'b0;
		forever #25 core_clk = ~core_clk;
	end

	// --------
	// helpers
	// --------
	task automatic check(input logic [63:0] seen, input logic [63:0] exp);
		total_checks++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR t=%0t got %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic print_verdict;
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict

	task automatic slot_pulse;
		@(posedge core_clk);
		#1;
		tx_slot_free = 1'b1;
		@(posedge core_clk);
		#1;
		tx_slot_free = 1'b0;
	endtask : slot_pulse

	// --------
	// scenarios
	// --------
	task automatic test_reset_values;
		check(reg_file_q, 64'h0);
		check({dev_oe, 47'h0, tx_buffer_empty}, 64'h0);
		$display("test_reset_values done");
	endtask : test_reset_values

	// every word written whole then read back whole
	task automatic test_word;
		for (int i = 0; i < 4; i++)
		begin
			exp_q[i] = {8'(8'hC0 + i), 8'(8'h30 + i)};
			HOST.xfer(1'b1, {2'(i), 1'b0}, 1'b0, 1'b1, exp_q[i], rd);
		end
		check(reg_file_q, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
		for (int i = 0; i < 4; i++)
		begin
			HOST.xfer(1'b0, {2'(i), 1'b0}, 1'b0, 1'b1, 16'h0000, rd);
			check(64'(rd), 64'(exp_q[i]));
		end
		$display("test_word done");
	endtask : test_word

	// an 8-bit host repeats its byte on both lanes; only the addressed lane may land
	task automatic test_byte;
		HOST.xfer(1'b1, 3'b011, 1'b1, 1'b1, 16'h9696, rd);
		HOST.xfer(1'b1, 3'b100, 1'b1, 1'b1, 16'h6969, rd);
		exp_q[1][15:8] = 8'h96;
		exp_q[2][7:0] = 8'h69;
		check(reg_file_q, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
		HOST.xfer(1'b0, 3'b011, 1'b1, 1'b1, 16'h0000, rd);
		check(64'(rd[15:8]), 64'(exp_q[1][15:8]));
		HOST.xfer(1'b0, 3'b100, 1'b1, 1'b1, 16'h0000, rd);
		check(64'(rd[7:0]), 64'(exp_q[2][7:0]));
		$display("test_byte done");
	endtask : test_byte

	task automatic test_ce_low;
		HOST.xfer(1'b1, 3'b000, 1'b0, 1'b0, 16'hFFFF, rd);
		HOST.xfer(1'b0, 3'b010, 1'b0, 1'b0, 16'h0000, rd);
		check(reg_file_q, {exp_q[3], exp_q[2], exp_q[1], exp_q[0]});
		check(64'(dev_oe), 64'h0);
		$display("test_ce_low done");
	endtask : test_ce_low

	task automatic test_tbe;
		slot_pulse();
		check(64'(tx_buffer_empty), 64'h1);
		HOST.xfer(1'b1, 3'b100, 1'b0, 1'b1, 16'h1111, rd);
		check(64'(tx_buffer_empty), 64'h1);
		HOST.xfer(1'b1, 3'b110, 1'b0, 1'b1, 16'h2222, rd);
		check(64'(tx_buffer_empty), 64'h0);
		// core frees the slot in the very cycle the word-3 write lands: the set wins
		fork
			HOST.xfer(1'b1, 3'b110, 1'b0, 1'b1, 16'h3333, rd);
			begin
				repeat (9) @(posedge core_clk);
				#1;
				tx_slot_free = 1'b1;
				@(posedge core_clk);
				#1;
				tx_slot_free = 1'b0;
			end
		join
		check(64'(reg_file_q[63:48]), 64'h3333);
		check(64'(tx_buffer_empty), 64'h1);
		$display("test_tbe done");
	endtask : test_tbe

	// a write strobed while reset is high must not land
	task automatic test_reset_pin;
		slot_pulse();
		reset_pin = 1'b1;
		HOST.xfer(1'b1, 3'b000, 1'b0, 1'b1, 16'h7777, rd);
		check(reg_file_q, 64'h0);
		check(64'(tx_buffer_empty), 64'h0);
		@(posedge core_clk);
		#1;
		reset_pin = 1'b0;
		repeat (6) @(posedge core_clk);
		check(reg_file_q, 64'h0);
		$display("test_reset_pin done");
	endtask : test_reset_pin

	// watchdog sized well above the few hundred cycles the tests need
	initial
	begin
		repeat (4000) @(posedge core_clk);
		miscompares++;
		$display("ERROR t=%0t watchdog expired", $time);
		print_verdict();
	end

	initial
	begin
		rstn = 1'b0;
		reset_pin = 1'b0;
		tx_slot_free = 1'b0;
		repeat (2) @(posedge core_clk);
		#1;
		rstn = 1'b1;
		@(posedge core_clk);
		#1;
		test_reset_values();
		test_word();
		test_byte();
		test_ce_low();
		test_tbe();
		test_reset_pin();
		print_verdict();
	end
endmodule : tb_top
